// [src/rerc_cfg.svh]
// Purpose: Constants of the regulator enable and reset control block
// Assumes: 100 MHz system clock
// Notes:   Offsets are byte addresses of the plain register port
`ifndef RERC_CFG_SVH
`define RERC_CFG_SVH
// ==========================================================
// Timing
`define RERC_CLK_MHZ   100
`define RERC_BIAS_US   170
`define RERC_RAMP_US   750
`define RERC_MS_US     1000
`define RERC_DEB_MS    30
`define RERC_HOLD_MS   100
// ==========================================================
// Register offsets
`define RERC_A_CTRL    8'h00
`define RERC_A_DISCH   8'h04
`define RERC_A_LINCTL  8'h08
`define RERC_A_LINV    8'h0C
`define RERC_A_CORE    8'h10
`define RERC_A_STAT    8'h14
// ==========================================================
// Field positions
`define RERC_B_PSMDIS  0
`define RERC_B_LOWRIP  3
`define RERC_B_LINDIS  0
// ==========================================================
// Reset and default values, millivolts
`define RERC_RST_CTRL  16'h0000
`define RERC_RST_DISCH 16'h0000
`define RERC_RST_LINDS 16'h0000
`define RERC_RST_LINV  16'h0000
`define RERC_SYS_LO_MV 16'h0BB8
`define RERC_SYS_HI_MV 16'h0CE4
`define RERC_MEM_LO_MV 16'h0708
`define RERC_MEM_HI_MV 16'h09C4
`define RERC_COR_LO_MV 16'h0514
`define RERC_COR_HI_MV 16'h060E
`endif

// [src/rerc_pkg.sv]
// Purpose: Types of the regulator enable and reset control block
// Assumes: Nothing
// Notes:   Constants live in rerc_cfg.svh
package rerc_pkg;
	// ==========================================================
	// Converter sequencing states
	typedef enum logic [1:0] {
		RERC_C_OFF  = 2'b00,
		RERC_C_BIAS = 2'b01,
		RERC_C_RAMP = 2'b10,
		RERC_C_ON   = 2'b11
	} rerc_conv_st_t;
	// ==========================================================
	// System reset states
	typedef enum logic [1:0] {
		RERC_R_LOW  = 2'b00,
		RERC_R_HOLD = 2'b01,
		RERC_R_RUN  = 2'b10
	} rerc_rst_st_t;
	// ==========================================================
	// Per converter settings and outputs
	typedef struct packed {
		logic psmDisable;
		logic lowRipple;
		logic dischargeEn;
	} rerc_conv_cfg_t;
	typedef struct packed {
		logic       switching;
		logic       discharge;
		logic       forcePwm;
		logic       lowRipple;
		logic [9:0] rampStep;
	} rerc_conv_out_t;
endpackage : rerc_pkg

// [src/rerc_conv.sv]
// Purpose: Start-up sequencing of one step-down converter
// Assumes: usTick is a one-cycle pulse once per microsecond
// Notes:   rampStep counts microseconds of soft start ramp
`timescale 1ns/1ps
`include "rerc_cfg.svh"
module rerc_conv
	import rerc_pkg::*;
#(
	parameter int BIAS_US   = `RERC_BIAS_US,
	parameter int RAMP_US   = `RERC_RAMP_US,
	parameter int US_CYCLES = `RERC_CLK_MHZ
) (
	input  wire logic           clk,
	input  wire logic           srst,
	input  wire logic           usTick,
	input  wire logic           enable,
	input  wire rerc_conv_cfg_t cfg,
	input  wire logic [9:0]     prechargeStep,
	output rerc_conv_out_t      out
);
	rerc_conv_st_t state_r;
	logic [9:0]    bias_r;
	logic [9:0]    step_r;
	logic [31:0]   enCyc_r;
	localparam logic [9:0] BIAS_LAST = 10'(BIAS_US - 1);
	localparam logic [9:0] RAMP_LAST = 10'(RAMP_US - 1);
	// ==========================================================
	// Sequencer
	always_ff @(posedge clk) begin
		if (srst) begin
			state_r <= RERC_C_OFF;
		end else begin
			unique case (state_r)
				RERC_C_OFF: begin
					if (enable) state_r <= RERC_C_BIAS; // [R13]
				end
				RERC_C_BIAS: begin
					if (!enable) state_r <= RERC_C_OFF;
					else if (usTick && bias_r == BIAS_LAST) state_r <= RERC_C_RAMP; // [R3]
				end
				RERC_C_RAMP: begin
					if (!enable) state_r <= RERC_C_OFF;
					else if (usTick && step_r == RAMP_LAST) state_r <= RERC_C_ON; // [R4]
				end
				RERC_C_ON: begin
					if (!enable) state_r <= RERC_C_OFF;
				end
			endcase
		end
	end
	// ==========================================================
	// Bias delay and ramp counters
	always_ff @(posedge clk) begin
		if (srst || state_r != RERC_C_BIAS) bias_r <= 10'h000;
		else if (usTick) bias_r <= bias_r + 10'h001; // [R3]
	end
	always_ff @(posedge clk) begin
		if (srst || state_r == RERC_C_OFF) begin
			step_r <= 10'h000;
		end else if (state_r == RERC_C_BIAS) begin
			step_r <= (prechargeStep > RAMP_LAST) ? RAMP_LAST : prechargeStep; // [R4]
		end else if (state_r == RERC_C_RAMP && usTick && step_r != RAMP_LAST) begin
			step_r <= step_r + 10'h001; // [R4]
		end
	end
	// ==========================================================
	// Outputs
	assign out.switching = state_r[1];
	assign out.discharge = (state_r == RERC_C_OFF) && cfg.dischargeEn; // [R5] [R6]
	assign out.forcePwm  = cfg.psmDisable; // [R2]
	assign out.lowRipple = cfg.lowRipple && !cfg.psmDisable && state_r[1]; // [R1]
	assign out.rampStep  = step_r;
	// ==========================================================
	// Checks
	always_ff @(posedge clk) begin
		if (srst || !enable) enCyc_r <= 32'h0;
		else if (enCyc_r != 32'hFFFFFFFF) enCyc_r <= enCyc_r + 32'h1;
	end
	bias_wait_a: assert property (@(posedge clk) disable iff (srst) // [R3]
		$rose(out.switching) |-> enCyc_r >= 32'((BIAS_US - 1) * US_CYCLES))
		else $error("switching began before bias delay");
	ramp_len_a: assert property (@(posedge clk) disable iff (srst) // [R4]
		$rose(state_r == RERC_C_ON) |-> $past(step_r) == RAMP_LAST)
		else $error("ramp ended early");
	disch_off_a: assert property (@(posedge clk) disable iff (srst) // [R5]
		out.discharge |-> !out.switching && cfg.dischargeEn)
		else $error("discharge while running or not enabled");
	ripple_a: assert property (@(posedge clk) disable iff (srst) // [R1]
		out.lowRipple |-> !out.forcePwm && cfg.lowRipple)
		else $error("low ripple outside pulse frequency operation");
	start_c: cover property (@(posedge clk) disable iff (srst) $rose(out.switching));
endmodule : rerc_conv

// [src/rerc_top.sv]
// Purpose: Regulator enable, power-good and system reset control
// Assumes: Comparator flags are asynchronous; pins synchronous
// Notes:   System reset is open drain, pulled low via oe
// ==========================================================
// Summary of operation
// R1: Low ripple bit applies during pulse frequency operation
// R2: Per converter power save disable forces fixed PWM
// R3: Wait 170 us bias before switching starts
// R4: Soft start ramp 750 us, shortened when precharged
// R5: Optional discharge of disabled converters, off by default
// R6: Discharge on lockout, enable low, or overtemperature
// R7: Power-good flag for each of five rails
// R8: Rail drop raises interrupt; flags readable in status
// R9: Disabled rail reports power good
// R10: Common linear enable plus software disable and voltage
// R11: Lockout or overtemperature shuts every regulator down
// R12: Undervoltage lockout disables all regulators
// R13: Converter follows its own enable input level
// R14: Default select pin picks lower or higher voltage
// R15: Warm reset restores core default only
// R16: Warm reset input is debounced
// R17: System reset low at power-up, low rail, hold
// R18: Debounced warm reset forces system reset low
// R19: Hold delay starts after always-on rail recovers
// R20: System reset output is open drain
// R21: Debounce needs 30 ms of steady assertion
// R22: Core voltage default on five listed conditions
// R23: Hold and debounce timed from low-rate timebase
// R24: Comparator flags pass two-stage synchroniser
`timescale 1ns/1ps
`include "rerc_cfg.svh"
module rerc_top
	import rerc_pkg::*;
#(
	parameter int US_CYCLES = `RERC_CLK_MHZ,
	parameter int MS_US     = `RERC_MS_US,
	parameter int DEB_MS    = `RERC_DEB_MS,
	parameter int BIAS_US   = `RERC_BIAS_US,
	parameter int RAMP_US   = `RERC_RAMP_US
) (
	input  wire logic             clk,
	input  wire logic             srst,
	input  wire logic [7:0]       regAddr,
	input  wire logic [15:0]      regWdata,
	input  wire logic             regWrite,
	input  wire logic             regRead,
	output logic [15:0]           regRdata,
	input  wire logic             systemRailEnable,
	input  wire logic             memoryRailEnable,
	input  wire logic             coreRailEnable,
	input  wire logic             linearRegsEnable,
	input  wire logic             systemRailDefaultSel,
	input  wire logic             memoryRailDefaultSel,
	input  wire logic             coreRailDefaultSel,
	input  wire logic             warmResetRequest,
	input  wire logic [15:0]      resetDelayCapPin,
	input  wire logic             supplyUndervoltageLockout,
	input  wire logic             thermalShutdownFlag,
	input  wire logic             alwaysOnRailLow,
	input  wire logic [4:0]       railLowRaw,
	input  wire logic [2:0][9:0]  prechargeStep,
	output rerc_conv_out_t [2:0]  convOut,
	output logic [1:0]            linearEnable,
	output logic [7:0]            linearVoltage,
	output logic [15:0]           systemVoltMv,
	output logic [15:0]           memoryVoltMv,
	output logic [15:0]           coreVoltMv,
	output logic [4:0]            railFaultStatus,
	output logic                  railFaultIrq,
	output logic                  systemResetOut,
	output logic                  systemResetOe
);
	// ==========================================================
	// Declarations
	logic [2:0]           flagS1_r;
	logic [2:0]           flagS2_r;
	logic [4:0]           railS1_r;
	logic [4:0]           railS2_r;
	logic                 uvloS;
	logic                 thermS;
	logic                 aonLowS;
	logic                 shutdown;
	logic [15:0]          usCnt_r;
	logic                 usTick;
	logic [15:0]          msCnt_r;
	logic                 msTick;
	logic [7:0]           debCnt_r;
	logic                 warmActive_r;
	rerc_rst_st_t         rstSt_r;
	logic [15:0]          hold_r;
	logic [15:0]          ctrl_r;
	logic [15:0]          disch_r;
	logic [15:0]          linDis_r;
	logic [15:0]          linV_r;
	logic [15:0]          core_r;
	logic [15:0]          coreDef;
	logic                 coreDefault;
	logic [2:0]           convEn;
	rerc_conv_cfg_t [2:0] convCfg;
	logic [4:0]           railOn;
	logic [4:0]           fault_nxt;
	logic [31:0]          warmCyc_r;
	localparam logic [15:0] US_LAST  = 16'(US_CYCLES - 1);
	localparam logic [15:0] MS_LAST  = 16'(MS_US - 1);
	localparam logic [7:0]  DEB_LAST = 8'(DEB_MS);
	// ==========================================================
	// Synchronisers for comparator flags
	always_ff @(posedge clk) begin
		if (srst) begin
			flagS1_r <= 3'h7;
			flagS2_r <= 3'h7;
			railS1_r <= 5'h00;
			railS2_r <= 5'h00;
		end else begin
			flagS1_r <= {alwaysOnRailLow, thermalShutdownFlag, supplyUndervoltageLockout}; // [R24]
			flagS2_r <= flagS1_r; // [R24]
			railS1_r <= railLowRaw; // [R24]
			railS2_r <= railS1_r; // [R24]
		end
	end
	assign uvloS    = flagS2_r[0];
	assign thermS   = flagS2_r[1];
	assign aonLowS  = flagS2_r[2];
	assign shutdown = uvloS || thermS; // [R11] [R12]
	// ==========================================================
	// Timebase
	always_ff @(posedge clk) begin
		if (srst || usCnt_r == US_LAST) usCnt_r <= 16'h0000;
		else usCnt_r <= usCnt_r + 16'h0001;
	end
	assign usTick = (usCnt_r == US_LAST);
	always_ff @(posedge clk) begin
		if (srst) msCnt_r <= 16'h0000;
		else if (usTick) msCnt_r <= (msCnt_r == MS_LAST) ? 16'h0000 : msCnt_r + 16'h0001;
	end
	assign msTick = usTick && (msCnt_r == MS_LAST); // [R23]
	// ==========================================================
	// Warm reset debounce
	always_ff @(posedge clk) begin
		if (srst || !warmResetRequest) begin
			debCnt_r     <= 8'h00;
			warmActive_r <= 1'b0;
		end else if (msTick) begin
			if (debCnt_r != DEB_LAST) debCnt_r <= debCnt_r + 8'h01; // [R23]
			if (debCnt_r == DEB_LAST - 8'h01) warmActive_r <= 1'b1; // [R16] [R21]
		end
	end
	// ==========================================================
	// System reset sequencing
	always_ff @(posedge clk) begin
		if (srst) begin
			rstSt_r <= RERC_R_LOW; // [R17]
		end else begin
			unique case (rstSt_r)
				RERC_R_LOW: begin
					if (!aonLowS && !warmActive_r) rstSt_r <= RERC_R_HOLD; // [R19]
				end
				RERC_R_HOLD: begin
					if (aonLowS || warmActive_r) rstSt_r <= RERC_R_LOW;
					else if (msTick && hold_r >= resetDelayCapPin) rstSt_r <= RERC_R_RUN; // [R23]
				end
				RERC_R_RUN: begin
					if (aonLowS || warmActive_r) rstSt_r <= RERC_R_LOW; // [R17] [R18]
				end
				default: rstSt_r <= RERC_R_LOW;
			endcase
		end
	end
	always_ff @(posedge clk) begin
		if (srst || rstSt_r != RERC_R_HOLD) hold_r <= 16'h0000;
		else if (msTick && hold_r != 16'hFFFF) hold_r <= hold_r + 16'h0001; // [R17]
	end
	always_ff @(posedge clk) begin
		if (srst) systemResetOe <= 1'b1;
		else systemResetOe <= (rstSt_r != RERC_R_RUN); // [R17] [R18]
	end
	assign systemResetOut = 1'b0; // [R20]
	// ==========================================================
	// Register writes
	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl_r   <= `RERC_RST_CTRL;
			disch_r  <= `RERC_RST_DISCH; // [R5]
			linDis_r <= `RERC_RST_LINDS;
			linV_r   <= `RERC_RST_LINV;
		end else if (regWrite) begin
			if (regAddr == `RERC_A_CTRL) ctrl_r <= regWdata; // [R1] [R2]
			if (regAddr == `RERC_A_DISCH) disch_r <= regWdata; // [R5]
			if (regAddr == `RERC_A_LINCTL) linDis_r <= regWdata; // [R10]
			if (regAddr == `RERC_A_LINV) linV_r <= regWdata; // [R10]
		end
	end
	// ==========================================================
	// Core voltage with default restore
	assign coreDef = coreRailDefaultSel ? `RERC_COR_HI_MV : `RERC_COR_LO_MV; // [R14]
	assign coreDefault = warmActive_r || aonLowS || uvloS || systemResetOe
		|| (!convEn[0] && !convEn[2]); // [R15] [R22]
	always_ff @(posedge clk) begin
		if (srst) core_r <= `RERC_COR_LO_MV;
		else if (coreDefault) core_r <= coreDef; // [R15] [R22]
		else if (regWrite && regAddr == `RERC_A_CORE) core_r <= regWdata;
	end
	assign coreVoltMv = core_r;
	always_ff @(posedge clk) begin
		if (srst) begin
			systemVoltMv <= `RERC_SYS_LO_MV;
			memoryVoltMv <= `RERC_MEM_LO_MV;
		end else begin
			systemVoltMv <= systemRailDefaultSel ? `RERC_SYS_HI_MV : `RERC_SYS_LO_MV; // [R14]
			memoryVoltMv <= memoryRailDefaultSel ? `RERC_MEM_HI_MV : `RERC_MEM_LO_MV; // [R14]
		end
	end
	// ==========================================================
	// Converters
	assign convEn = {coreRailEnable, memoryRailEnable, systemRailEnable} & {3{!shutdown}}; // [R13]
	for (genvar i = 0; i < 3; i++) begin : gConv
		assign convCfg[i].psmDisable  = ctrl_r[`RERC_B_PSMDIS + i]; // [R2]
		assign convCfg[i].lowRipple   = ctrl_r[`RERC_B_LOWRIP]; // [R1]
		assign convCfg[i].dischargeEn = disch_r[i]; // [R5] [R6]
		rerc_conv #(
			.BIAS_US   (BIAS_US),
			.RAMP_US   (RAMP_US),
			.US_CYCLES (US_CYCLES)
		) uConv (
			.clk           (clk),
			.srst          (srst),
			.usTick        (usTick),
			.enable        (convEn[i]),
			.cfg           (convCfg[i]),
			.prechargeStep (prechargeStep[i]),
			.out           (convOut[i])
		);
	end
	// ==========================================================
	// Linear regulators
	always_ff @(posedge clk) begin
		if (srst) linearEnable <= 2'b00;
		else linearEnable <= {2{linearRegsEnable && !shutdown}}
			& ~linDis_r[`RERC_B_LINDIS +: 2]; // [R10] [R11]
	end
	assign linearVoltage = linV_r[7:0]; // [R10]
	// ==========================================================
	// Power-good flags
	assign railOn    = {linearEnable, convEn};
	assign fault_nxt = railS2_r & railOn; // [R7] [R9]
	always_ff @(posedge clk) begin
		if (srst) begin
			railFaultStatus <= 5'h00;
			railFaultIrq    <= 1'b0;
		end else begin
			railFaultStatus <= fault_nxt; // [R7] [R9]
			railFaultIrq    <= |fault_nxt; // [R8]
		end
	end
	// ==========================================================
	// Register reads
	always_ff @(posedge clk) begin
		if (srst || !regRead) begin
			regRdata <= 16'h0000;
		end else begin
			unique case (regAddr)
				`RERC_A_CTRL:   regRdata <= ctrl_r;
				`RERC_A_DISCH:  regRdata <= disch_r;
				`RERC_A_LINCTL: regRdata <= linDis_r;
				`RERC_A_LINV:   regRdata <= linV_r;
				`RERC_A_CORE:   regRdata <= core_r;
				`RERC_A_STAT:   regRdata <= {7'h00, warmActive_r, aonLowS, thermS, uvloS,
					railFaultStatus}; // [R8]
				default:        regRdata <= 16'h0000;
			endcase
		end
	end
	// ==========================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	always_ff @(posedge clk) begin
		if (srst || !warmResetRequest) warmCyc_r <= 32'h0;
		else if (warmCyc_r != 32'hFFFFFFFF) warmCyc_r <= warmCyc_r + 32'h1;
	end
	shut_off_a: assert property (shutdown |=> !convOut[0].switching // [R11]
		&& !convOut[1].switching && !convOut[2].switching)
		else $error("converter runs during shutdown");
	lin_off_a: assert property (uvloS |=> linearEnable == 2'b00) // [R12]
		else $error("linear regulator on during lockout");
	disch_on_a: assert property (!convEn[0] && disch_r[0] |=> convOut[0].discharge) // [R6]
		else $error("disabled converter not discharged");
	pg_idle_a: assert property (!railOn[3] |=> !railFaultStatus[3]) // [R9]
		else $error("disabled rail reported bad");
	pg_flag_a: assert property (railS2_r[0] && convEn[0] |=> railFaultStatus[0] // [R7]
		&& railFaultIrq) // [R8]
		else $error("rail drop not flagged");
	deb_time_a: assert property ($rose(warmActive_r) |-> // [R21]
		warmCyc_r >= 32'((DEB_MS - 1) * MS_US * US_CYCLES))
		else $error("warm reset accepted before debounce time");
	rst_low_a: assert property (aonLowS || warmActive_r |=> ##1 systemResetOe) // [R17] [R18]
		else $error("system reset released while held");
	rst_hold_a: assert property ($fell(systemResetOe) |-> // [R19]
		$past(rstSt_r, 2) == RERC_R_HOLD && !aonLowS)
		else $error("system reset released without hold");
	core_def_a: assert property (coreDefault |=> coreVoltMv == $past(coreDef)) // [R22]
		else $error("core voltage not restored");
	// ==========================================================
	// Linear, converter, flag, default, bus and reset checks
	lin_dis_a: assert property (linDis_r[`RERC_B_LINDIS] // [R10]
		|=> !linearEnable[0])
		else $error("disabled linear regulator still on");
	lin_on_a: assert property (linearRegsEnable && !shutdown // [R10]
		&& linDis_r[`RERC_B_LINDIS +: 2] == 2'b00 |=> linearEnable == 2'b11)
		else $error("linear regulators not enabled together");
	therm_lin_a: assert property (thermS |=> linearEnable == 2'b00) // [R11]
		else $error("linear regulator on while hot");
	irq_rail_a: assert property (railS2_r[4] && railOn[4] |=> railFaultIrq // [R8]
		&& railFaultStatus[4])
		else $error("linear rail drop not flagged");
	conv_off_a: assert property (!coreRailEnable |=> !convOut[2].switching) // [R13]
		else $error("core converter runs while disabled");
	deb_clr_a: assert property (!warmResetRequest |=> !warmActive_r) // [R16]
		else $error("warm reset held without request");
	sys_def_a: assert property (systemRailDefaultSel |=> // [R14]
		systemVoltMv == `RERC_SYS_HI_MV)
		else $error("system rail default not high");
	mem_def_a: assert property (!memoryRailDefaultSel |=> // [R14]
		memoryVoltMv == `RERC_MEM_LO_MV)
		else $error("memory rail default not low");
	rdata_idle_a: assert property (!regRead |=> regRdata == 16'h0000)
		else $error("read data outside read cycle");
	stat_rd_a: assert property (regRead && regAddr == `RERC_A_STAT |=> // [R8]
		regRdata[4:0] == $past(railFaultStatus))
		else $error("status read lost rail flags");
	oe_run_a: assert property (rstSt_r == RERC_R_RUN |=> !systemResetOe) // [R20]
		else $error("system reset line not released");
	supply_undervoltage_lockout_core_a: assert property (uvloS |=> // [R22]
		coreVoltMv == $past(coreDef))
		else $error("core voltage kept during lockout");
	warm_core_a: assert property (warmActive_r |=> coreVoltMv == $past(coreDef)) // [R15]
		else $error("core voltage kept during warm reset");
	warm_c: cover property ($rose(warmActive_r));
	rel_c: cover property ($fell(systemResetOe));
	fault_c: cover property ($rose(railFaultIrq));
	disch_c: cover property ($rose(convOut[2].discharge));
endmodule : rerc_top

// [sim/rerc_host_model.sv]
// Purpose: Far-side model of the open-drain system reset line
// Assumes: The board pulls the line up when nobody drives it low
// Notes:   Line level is resolved from the single driver's enable
`timescale 1ns/1ps
module rerc_host_model (
	input  wire logic sysRstOut,
	input  wire logic sysRstOe,
	output logic      resetLine
);
	// ==========================================================
	// Open-drain line with pull-up
	assign resetLine = sysRstOe ? sysRstOut : 1'b1;
endmodule : rerc_host_model

// [sim/rerc_tb.sv]
// Purpose: Self-checking bench of the regulator enable and reset block
// Assumes: Shortened timebase, 2 cycles per us and 4 us per ms
// Notes:   Expected values are worked out here from the pin levels
`timescale 1ns/1ps
`include "rerc_cfg.svh"
module rerc_tb
	import rerc_pkg::*;
();
	localparam int MSC = 8;
	logic                 clk, srst, regWrite, regRead;
	logic [7:0]           regAddr, linV;
	logic [15:0]          regWdata, regRdata, sysMv, memMv, coreMv, capPin;
	logic                 sysEn, memEn, coreEn, linEn, sysSel, memSel, coreSel;
	logic                 warmReq, supply_undervoltage_lockout, hot, aonLow, irq, rstOut, rstOe, resetLine;
	logic [4:0]           railLow, faultSt;
	logic [2:0][9:0]      preStep;
	rerc_conv_out_t [2:0] convOut;
	logic [1:0]           linOut;
	logic [3:0]           ctrl;
	logic [31:0]          seed;
	logic [7:0]           addrs [5];
	int                   miscompares, checked, n;
	// ==========================================================
	// Design and far side
	rerc_top #(.US_CYCLES(2), .MS_US(4), .DEB_MS(3), .BIAS_US(4), .RAMP_US(8)) i_rerc_top (
		.clk(clk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata),
		.regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
		.systemRailEnable(sysEn), .memoryRailEnable(memEn), .coreRailEnable(coreEn),
		.linearRegsEnable(linEn), .systemRailDefaultSel(sysSel),
		.memoryRailDefaultSel(memSel), .coreRailDefaultSel(coreSel),
		.warmResetRequest(warmReq), .resetDelayCapPin(capPin),
		.supplyUndervoltageLockout(supply_undervoltage_lockout), .thermalShutdownFlag(hot),
		.alwaysOnRailLow(aonLow), .railLowRaw(railLow), .prechargeStep(preStep),
		.convOut(convOut), .linearEnable(linOut), .linearVoltage(linV),
		.systemVoltMv(sysMv), .memoryVoltMv(memMv), .coreVoltMv(coreMv),
		.railFaultStatus(faultSt), .railFaultIrq(irq),
		.systemResetOut(rstOut), .systemResetOe(rstOe));
	rerc_host_model i_rerc_host_model (.sysRstOut(rstOut), .sysRstOe(rstOe),
		.resetLine(resetLine));
	// ==========================================================
	// Clock and watchdog
	initial clk = 1'b0;
	always #5 clk = ~clk;
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		summarize();
	end
	// ==========================================================
	// Helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic step(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : step
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic chkIn(input string nm, input int got, input int lo, input int hi);
		checked++;
		if (got < lo || got > hi) begin
			miscompares++;
			$display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
		end
	endtask : chkIn
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		regAddr  <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
		step(1);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string nm);
		@(posedge clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		#1;
		chk(nm, exp, regRdata);
	endtask : rd
	task automatic waitOe(input logic v);
		n = 0;
		while (rstOe !== v && n < 300) begin
			step(1);
			n++;
		end
	endtask : waitOe
	task automatic summarize();
		if (miscompares == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : summarize
	// ==========================================================
	// Main sequence
	initial begin
		{srst, regWrite, regRead, regAddr, regWdata} = {1'b1, 2'b00, 8'h00, 16'h0000};
		{sysEn, memEn, coreEn, linEn, sysSel, memSel, coreSel} = 7'h00;
		{warmReq, supply_undervoltage_lockout, hot, aonLow, railLow} = 9'h000;
		capPin  = 16'h0002;
		preStep = {10'h002, 10'h000, 10'h005};
		seed    = 32'h3D5E;
		addrs   = '{`RERC_A_CTRL, `RERC_A_DISCH, `RERC_A_LINCTL, `RERC_A_LINV, 8'h18};
		step(16);
		chk("resetLine", 16'h0000, {15'h0000, resetLine});
		@(posedge clk) srst <= 1'b0;
		waitOe(1'b0);
		chkIn("holdCycles", n, MSC, 4 * MSC + 8);
		chk("lineIdle", 16'h0001, {15'h0000, resetLine});
		foreach (addrs[i]) rd(addrs[i], 16'h0000, "regReset");
		for (int k = 0; k < 8; k++) begin
			@(posedge clk) {coreSel, memSel, sysSel} <= k[2:0];
			step(3);
			chk("sysMv", sysSel ? `RERC_SYS_HI_MV : `RERC_SYS_LO_MV, sysMv);
			chk("memMv", memSel ? `RERC_MEM_HI_MV : `RERC_MEM_LO_MV, memMv);
			chk("coreMv", coreSel ? `RERC_COR_HI_MV : `RERC_COR_LO_MV, coreMv);
		end
		seed = lfsr(seed);
		ctrl = seed[3:0];
		wr(`RERC_A_CTRL, {12'h000, ctrl});
		wr(`RERC_A_DISCH, 16'h0005);
		@(posedge clk) {coreEn, memEn, sysEn} <= 3'b111;
		n = 0;
		while (convOut[0].switching !== 1'b1 && n < 100) begin
			step(1);
			n++;
		end
		chkIn("biasCycles", n, 6, 12);
		for (int i = 0; i < 3; i++)
			chk("rampStart", {6'h00, preStep[i]}, {6'h00, convOut[i].rampStep});
		step(2);
		for (int i = 0; i < 3; i++) begin
			chk("switching", 16'h0001, {15'h0000, convOut[i].switching});
			chk("forcePwm", {15'h0000, ctrl[i]}, {15'h0000, convOut[i].forcePwm});
			chk("dischOn", 16'h0000, {15'h0000, convOut[i].discharge});
			if (!ctrl[i]) chk("lowRip", {15'h0000, ctrl[3]}, {15'h0000, convOut[i].lowRipple});
		end
		@(posedge clk) linEn <= 1'b1;
		step(3);
		chk("linBoth", 16'h0003, {14'h0000, linOut});
		wr(`RERC_A_LINCTL, 16'h0001);
		seed = lfsr(seed);
		wr(`RERC_A_LINV, {8'h00, seed[7:0]});
		step(1);
		chk("linDis", 16'h0002, {14'h0000, linOut});
		chk("linV", {8'h00, seed[7:0]}, {8'h00, linV});
		wr(`RERC_A_CORE, 16'h0384);
		step(1);
		chk("coreWr", 16'h0384, coreMv);
		@(posedge clk) warmReq <= 1'b1;
		step(MSC);
		@(posedge clk) warmReq <= 1'b0;
		step(4 * MSC);
		chk("glitch", 16'h0000, {15'h0000, rstOe});
		for (int i = 0; i < 3; i++)
			chk("rampEnd", 16'h0007, {6'h00, convOut[i].rampStep});
		@(posedge clk) warmReq <= 1'b1;
		waitOe(1'b1);
		chkIn("debounce", n, 2 * MSC, 3 * MSC + 6);
		step(2);
		chk("coreDef", `RERC_COR_HI_MV, coreMv);
		rd(`RERC_A_CTRL, {12'h000, ctrl}, "ctrlKept");
		@(posedge clk) warmReq <= 1'b0;
		waitOe(1'b0);
		chkIn("warmHold", n, MSC, 4 * MSC + 8);
		@(posedge clk) memEn <= 1'b0;
		@(posedge clk) railLow <= 5'h1F;
		step(4);
		chk("fault", 16'h0015, {11'h000, faultSt});
		chk("irq", 16'h0001, {15'h0000, irq});
		rd(`RERC_A_STAT, 16'h0015, "status");
		@(posedge clk) railLow <= 5'h00;
		step(4);
		chk("irqClr", 16'h0000, {15'h0000, irq});
		for (int k = 0; k < 2; k++) begin
			wr(`RERC_A_CORE, 16'h0384);
			@(posedge clk) {hot, supply_undervoltage_lockout} <= (k == 0) ? 2'b01 : 2'b10;
			step(5);
			chk("shutSw", 16'h0000, {15'h0000, convOut[2].switching});
			chk("shutDis", 16'h0001, {15'h0000, convOut[0].discharge});
			chk("noDis", 16'h0000, {15'h0000, convOut[1].discharge});
			chk("shutLin", 16'h0000, {14'h0000, linOut});
			if (k == 0) chk("uvloCore", `RERC_COR_HI_MV, coreMv);
			@(posedge clk) {hot, supply_undervoltage_lockout} <= 2'b00;
			step(20);
		end
		@(posedge clk) aonLow <= 1'b1;
		step(5);
		chk("aonLow", 16'h0001, {15'h0000, rstOe});
		@(posedge clk) aonLow <= 1'b0;
		waitOe(1'b0);
		chkIn("aonHold", n, MSC, 4 * MSC + 8);
		@(posedge clk) sysEn <= 1'b0;
		step(3);
		chk("offSw", 16'h0000, {15'h0000, convOut[0].switching});
		chk("offDis", 16'h0001, {15'h0000, convOut[0].discharge});
		summarize();
	end
endmodule : rerc_tb
